// ---- hdl/eic_pkg.sv ----
// Shared constants and carrier types for the external interrupt and core control block
package eic_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_EXT_IRQ_CONFIG = 8'h0b;
   localparam logic [7:0] IDX_IRQ_MASK_ONE = 8'h0e;
   localparam logic [7:0] IDX_IRQ_MASK_TWO = 8'h0f;
   localparam logic [7:0] IDX_CORE_CONTROL = 8'h10;
   localparam logic [7:0] IDX_IRQ_PENDING = 8'h11;

   // Reset values
   localparam logic [7:0] RST_EXT_IRQ_CONFIG = 8'h00;
   localparam logic [7:0] RST_IRQ_MASK = 8'h00;
   localparam logic [7:0] RST_CORE_CONTROL = 8'h00;

   // Writable bits; the rest are reserved and read zero
   localparam logic [7:0] WMASK_EXT_IRQ_CONFIG = 8'hdb;
   localparam logic [7:0] WMASK_IRQ_MASK_ONE = 8'hef;
   localparam logic [7:0] WMASK_IRQ_MASK_TWO = 8'h7d;

   // ext_irq_config fields
   localparam int CFG_PIN_ONE_NOISE_SEL = 7;
   localparam int CFG_PIN_ZERO_FUNC_EN = 6;
   localparam int CFG_PIN_THREE_EDGE_HI = 4;
   localparam int CFG_PIN_THREE_EDGE_LO = 3;
   localparam int CFG_PIN_ONE_EDGE_SEL = 1;
   localparam int CFG_TIMER_TWO_EDGE_SEL = 0;

   // irq_mask_one fields
   localparam int M1_PIN_FIVE_IRQ_EN = 7;
   localparam int M1_TIMER_TWO_IRQ_EN = 6;
   localparam int M1_ADC_DONE_IRQ_EN = 5;
   localparam int M1_PIN_THREE_IRQ_EN = 3;
   localparam int M1_TIMER_FOUR_IRQ_EN = 2;
   localparam int M1_SERIAL_IF_IRQ_EN = 1;
   localparam int M1_TIMER_THREE_IRQ_EN = 0;
   // irq_mask_two field
   localparam int M2_PIN_ONE_IRQ_EN = 2;

   // core_control fields
   localparam int CC_WATCHDOG_OUT_SEL = 7;
   localparam int CC_GLOBAL_IRQ_EN = 6;
   localparam int CC_WATCHDOG_DIV_HI = 5;
   localparam int CC_WATCHDOG_DIV_LO = 4;
   localparam int CC_WATCHDOG_RUN_EN = 3;
   localparam int CC_TIMER_DIV_B2 = 2;
   localparam int CC_TIMER_DIV_B0 = 0;

   // Pending flag positions
   localparam int NUM_SRC = 10;
   localparam int SRC_TIMER_THREE = 0;
   localparam int SRC_SERIAL_IF = 1;
   localparam int SRC_TIMER_FOUR = 2;
   localparam int SRC_PIN_THREE = 3;
   localparam int SRC_PIN_ONE = 4;
   localparam int SRC_ADC_DONE = 5;
   localparam int SRC_TIMER_TWO = 6;
   localparam int SRC_PIN_FIVE = 7;
   localparam int SRC_PIN_ZERO = 8;
   localparam int SRC_WATCHDOG = 9;

   // Pin three edge codes
   localparam logic [1:0] EDGE3_RISE = 2'h0;
   localparam logic [1:0] EDGE3_FALL = 2'h1;
   localparam logic [1:0] EDGE3_BOTH = 2'h2;

   // Noise reject times in Fc periods; Fc is pclk
   localparam int NR_LONG_FC = 63;
   localparam int NR_SHORT_FC = 15;
   localparam int NR_PIN3_FC = 7;
   localparam int PCLK_PER_FC = 1;
   localparam logic [5:0] NR_LONG_CYC = 6'(NR_LONG_FC * PCLK_PER_FC);
   localparam logic [5:0] NR_SHORT_CYC = 6'(NR_SHORT_FC * PCLK_PER_FC);
   localparam logic [5:0] NR_PIN3_CYC = 6'(NR_PIN3_FC * PCLK_PER_FC);

   // Watchdog time-out in prescaled ticks
   localparam int WDT_TICKS_DEF = 256;

   // Instruction events from the core, one-cycle pulses
   typedef struct packed {
      logic enable_irqs_instr;
      logic disable_irqs_instr;
      logic return_irq_instr;
      logic irq_taken;
   } eic_core_instr_s;

   // Peripheral interrupt events, one-cycle pulses
   typedef struct packed {
      logic timer_two;
      logic adc_done;
      logic timer_four;
      logic serial_if;
      logic timer_three;
   } eic_periph_s;
endpackage

// ---- hdl/eic_noise_filter.sv ----
// Digital noise filter: accepts a new level only after it holds long enough
`timescale 1ns/100ps
module eic_noise_filter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic raw,
   input wire logic [5:0] hold_cyc,
   output logic level
);
   logic [5:0] cnt_q;
   logic [5:0] cnt_d;
   logic level_q;
   logic level_d;
   wire differ = raw != level_q;
   wire accept = differ && (cnt_q == hold_cyc - 6'h01);

   // Count consecutive cycles of a differing level; shorter pulses vanish
   always_comb begin
      cnt_d = differ ? cnt_q + 6'h01 : 6'h00;
      level_d = level_q;
      if (accept) begin
         cnt_d = 6'h00;
         level_d = raw;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 6'h00;
         level_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         level_q <= level_d;
      end
   end

   assign level = level_q;

   // A change of output needs the raw level held for hold_cyc cycles
   a_filter_hold: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(level_q) |-> $past(raw) == level_q && $past(cnt_q) == $past(hold_cyc) - 6'h01)
      else $error("filter changed level without full hold time");
endmodule

// ---- hdl/eic_top.sv ----
// External interrupt front end, mask and global enable, core control with watchdog
`timescale 1ns/100ps
module eic_top #(
   parameter int WDT_TICKS = eic_pkg::WDT_TICKS_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_irq_pin_zero,
   input wire logic ext_irq_pin_one,
   input wire logic ext_irq_pin_three,
   input wire logic ext_irq_pin_five,
   input wire logic timer_two_pin,
   input wire eic_pkg::eic_periph_s periph_evt,
   input wire eic_pkg::eic_core_instr_s core_instr,
   input wire logic watchdog_clear,
   output logic irq_req,
   output logic [9:0] irq_src,
   output logic pin_zero_gpio,
   output logic timer_two_count,
   output logic base_timer_tick,
   output logic watchdog_reset
);
   logic [7:0] cfg_q;
   logic [7:0] mask_one_q;
   logic [7:0] mask_two_q;
   logic [7:0] core_q;
   logic [7:0] core_d;
   logic [9:0] pend_q;
   logic [9:0] pend_d;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [7:0] pre_q;
   logic [15:0] wdt_cnt_q;
   logic wdt_rst_q;
   logic tmr_tick_q;
   logic tc2_cnt_q;
   logic [9:0] src_q;
   logic pin0_prev_q;
   logic pin5_prev_q;
   logic pin1_prev_q;
   logic pin3_prev_q;
   logic tc2_prev_q;
   logic pin1_lvl;
   logic pin3_lvl;

   // Index hit for a word-aligned register
   function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
      return (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) && (addr[9:2] == idx);
   endfunction

   // True once every lg low bits of the prescaler are ones: a 1:2^lg tick
   function automatic logic div_hit(input logic [7:0] cnt, input logic [3:0] lg);
      logic [7:0] m;
      m = 8'hff >> (4'h8 - lg);
      return (cnt & m) == m;
   endfunction

   // APB decode
   wire setup = psel && !penable;
   wire access = psel && penable;
   wire hit_cfg = reg_hit(paddr, eic_pkg::IDX_EXT_IRQ_CONFIG);
   wire hit_m1 = reg_hit(paddr, eic_pkg::IDX_IRQ_MASK_ONE);
   wire hit_m2 = reg_hit(paddr, eic_pkg::IDX_IRQ_MASK_TWO);
   wire hit_cc = reg_hit(paddr, eic_pkg::IDX_CORE_CONTROL);
   wire hit_pend = reg_hit(paddr, eic_pkg::IDX_IRQ_PENDING);
   wire mapped = hit_cfg || hit_m1 || hit_m2 || hit_cc || hit_pend;
   wire wr = access && pwrite && mapped;
   wire [7:0] wbyte = pwdata[7:0];
   wire [31:0] rd_mux = hit_cfg ? {24'h0, cfg_q} :
                        hit_m1 ? {24'h0, mask_one_q} :
                        hit_m2 ? {24'h0, mask_two_q} :
                        hit_cc ? {24'h0, core_q} :
                        hit_pend ? {22'h0, pend_q} : 32'h0;

   // Zero-wait slave; read data captured in setup so it comes from a flop
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q && access;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= pwrite ? 32'h0 : rd_mux;
         pslverr_q <= !mapped;
      end
   end

   // Configuration and mask registers; reserved bits never store
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= eic_pkg::RST_EXT_IRQ_CONFIG;
         mask_one_q <= eic_pkg::RST_IRQ_MASK;
         mask_two_q <= eic_pkg::RST_IRQ_MASK;
      end else if (wr) begin
         if (hit_cfg) cfg_q <= wbyte & eic_pkg::WMASK_EXT_IRQ_CONFIG;
         if (hit_m1) mask_one_q <= wbyte & eic_pkg::WMASK_IRQ_MASK_ONE;
         if (hit_m2) mask_two_q <= wbyte & eic_pkg::WMASK_IRQ_MASK_TWO;
      end
   end

   // Config fields
   wire nr_short = cfg_q[eic_pkg::CFG_PIN_ONE_NOISE_SEL];
   wire pin0_en = cfg_q[eic_pkg::CFG_PIN_ZERO_FUNC_EN];
   wire [1:0] edge3 = {cfg_q[eic_pkg::CFG_PIN_THREE_EDGE_HI],
                       cfg_q[eic_pkg::CFG_PIN_THREE_EDGE_LO]};
   wire pin1_fall = cfg_q[eic_pkg::CFG_PIN_ONE_EDGE_SEL];
   wire tc2_fall = cfg_q[eic_pkg::CFG_TIMER_TWO_EDGE_SEL];

   // Noise-rejected copies of pins one and three
   wire [5:0] pin1_hold = nr_short ? eic_pkg::NR_SHORT_CYC : eic_pkg::NR_LONG_CYC;

   eic_noise_filter u_pin_one_filter (
      .pclk(pclk),
      .presetn(presetn),
      .raw(ext_irq_pin_one),
      .hold_cyc(pin1_hold),
      .level(pin1_lvl)
   );

   eic_noise_filter u_pin_three_filter (
      .pclk(pclk),
      .presetn(presetn),
      .raw(ext_irq_pin_three),
      .hold_cyc(eic_pkg::NR_PIN3_CYC),
      .level(pin3_lvl)
   );

   // Edge detection on the filtered or raw pins
   wire pin0_fall_evt = pin0_prev_q && !ext_irq_pin_zero && pin0_en;
   wire pin5_fall_evt = pin5_prev_q && !ext_irq_pin_five;
   wire pin1_rise = !pin1_prev_q && pin1_lvl;
   wire pin1_drop = pin1_prev_q && !pin1_lvl;
   wire pin1_evt = pin1_fall ? pin1_drop : pin1_rise;
   wire pin3_rise = !pin3_prev_q && pin3_lvl;
   wire pin3_drop = pin3_prev_q && !pin3_lvl;
   // Code 11 is reserved and raises nothing
   wire pin3_evt = (edge3 == eic_pkg::EDGE3_RISE) ? pin3_rise :
                   (edge3 == eic_pkg::EDGE3_FALL) ? pin3_drop :
                   (edge3 == eic_pkg::EDGE3_BOTH) ? (pin3_rise || pin3_drop) : 1'b0;
   wire tc2_evt = tc2_fall ? (tc2_prev_q && !timer_two_pin) :
                             (!tc2_prev_q && timer_two_pin);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin0_prev_q <= 1'b1;
         pin5_prev_q <= 1'b1;
         pin1_prev_q <= 1'b0;
         pin3_prev_q <= 1'b0;
         tc2_prev_q <= 1'b0;
      end else begin
         pin0_prev_q <= ext_irq_pin_zero;
         pin5_prev_q <= ext_irq_pin_five;
         pin1_prev_q <= pin1_lvl;
         pin3_prev_q <= pin3_lvl;
         tc2_prev_q <= timer_two_pin;
      end
   end

   // Pin zero feeds the port as plain I/O when its function is off
   assign pin_zero_gpio = pin0_en ? 1'b1 : ext_irq_pin_zero;

   // Core control fields
   wire wdt_to_reset = core_q[eic_pkg::CC_WATCHDOG_OUT_SEL];
   wire gie = core_q[eic_pkg::CC_GLOBAL_IRQ_EN];
   wire [1:0] wdt_div = {core_q[eic_pkg::CC_WATCHDOG_DIV_HI], core_q[eic_pkg::CC_WATCHDOG_DIV_LO]};
   wire wdt_run = core_q[eic_pkg::CC_WATCHDOG_RUN_EN];
   wire [2:0] tmr_div = core_q[eic_pkg::CC_TIMER_DIV_B2:eic_pkg::CC_TIMER_DIV_B0];

   // Prescaler taps: watchdog 4^(n+1), timer 2^(n+1)
   wire wdt_tick = div_hit(pre_q, {1'b0, wdt_div, 1'b0} + 4'h2);
   wire tmr_tick = div_hit(pre_q, {1'b0, tmr_div} + 4'h1);
   wire wdt_expire = wdt_run && wdt_tick && (wdt_cnt_q == 16'(WDT_TICKS - 1));

   // Watchdog counter; held in reset while disabled so it restarts cleanly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 8'h00;
         wdt_cnt_q <= 16'h0000;
         wdt_rst_q <= 1'b0;
         tmr_tick_q <= 1'b0;
         tc2_cnt_q <= 1'b0;
      end else begin
         pre_q <= pre_q + 8'h01;
         tmr_tick_q <= tmr_tick;
         tc2_cnt_q <= tc2_evt;
         wdt_rst_q <= wdt_expire && wdt_to_reset;
         if (!wdt_run || watchdog_clear || wdt_expire) begin
            wdt_cnt_q <= 16'h0000;
         end else if (wdt_tick) begin
            wdt_cnt_q <= wdt_cnt_q + 16'h0001;
         end
      end
   end

   assign base_timer_tick = tmr_tick_q;
   assign timer_two_count = tc2_cnt_q;
   assign watchdog_reset = wdt_rst_q;

   // Raw event vector in pending-flag order
   wire [9:0] evt;
   assign evt[eic_pkg::SRC_TIMER_THREE] = periph_evt.timer_three;
   assign evt[eic_pkg::SRC_SERIAL_IF] = periph_evt.serial_if;
   assign evt[eic_pkg::SRC_TIMER_FOUR] = periph_evt.timer_four;
   assign evt[eic_pkg::SRC_PIN_THREE] = pin3_evt;
   assign evt[eic_pkg::SRC_PIN_ONE] = pin1_evt;
   assign evt[eic_pkg::SRC_ADC_DONE] = periph_evt.adc_done;
   assign evt[eic_pkg::SRC_TIMER_TWO] = periph_evt.timer_two;
   assign evt[eic_pkg::SRC_PIN_FIVE] = pin5_fall_evt;
   assign evt[eic_pkg::SRC_PIN_ZERO] = pin0_fall_evt;
   assign evt[eic_pkg::SRC_WATCHDOG] = wdt_expire && !wdt_to_reset;

   // Per-source enables from the mask registers; pin zero uses its function enable, the watchdog is always enabled
   wire [9:0] src_en;
   assign src_en[eic_pkg::SRC_TIMER_THREE] = mask_one_q[eic_pkg::M1_TIMER_THREE_IRQ_EN];
   assign src_en[eic_pkg::SRC_SERIAL_IF] = mask_one_q[eic_pkg::M1_SERIAL_IF_IRQ_EN];
   assign src_en[eic_pkg::SRC_TIMER_FOUR] = mask_one_q[eic_pkg::M1_TIMER_FOUR_IRQ_EN];
   assign src_en[eic_pkg::SRC_PIN_THREE] = mask_one_q[eic_pkg::M1_PIN_THREE_IRQ_EN];
   assign src_en[eic_pkg::SRC_PIN_ONE] = mask_two_q[eic_pkg::M2_PIN_ONE_IRQ_EN];
   assign src_en[eic_pkg::SRC_ADC_DONE] = mask_one_q[eic_pkg::M1_ADC_DONE_IRQ_EN];
   assign src_en[eic_pkg::SRC_TIMER_TWO] = mask_one_q[eic_pkg::M1_TIMER_TWO_IRQ_EN];
   assign src_en[eic_pkg::SRC_PIN_FIVE] = mask_one_q[eic_pkg::M1_PIN_FIVE_IRQ_EN];
   assign src_en[eic_pkg::SRC_PIN_ZERO] = pin0_en;
   assign src_en[eic_pkg::SRC_WATCHDOG] = 1'b1;

   // Pending flags: write one to clear, a new event in the same cycle wins
   always_comb begin
      pend_d = pend_q;
      if (wr && hit_pend) pend_d = pend_q & ~pwdata[9:0];
      pend_d = pend_d | evt;
   end

   // Global enable: instructions override software writes; disable wins
   always_comb begin
      core_d = core_q;
      if (wr && hit_cc) core_d = wbyte;
      if (core_instr.enable_irqs_instr || core_instr.return_irq_instr) begin
         core_d[eic_pkg::CC_GLOBAL_IRQ_EN] = 1'b1;
      end
      if (core_instr.disable_irqs_instr || core_instr.irq_taken) begin
         core_d[eic_pkg::CC_GLOBAL_IRQ_EN] = 1'b0;
      end
   end

   wire [9:0] active = pend_q & src_en;
   assign irq_req = gie && (active != 10'h000);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= 10'h000;
         core_q <= eic_pkg::RST_CORE_CONTROL;
         src_q <= 10'h000;
      end else begin
         pend_q <= pend_d;
         core_q <= core_d;
         src_q <= active;
      end
   end

   // Enabled pending sources, registered for the core's vector logic
   assign irq_src = src_q;

   // Checks
   a_masked_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      pend_q == 10'(1 << eic_pkg::SRC_ADC_DONE) && !mask_one_q[eic_pkg::M1_ADC_DONE_IRQ_EN]
      |-> !irq_req)
      else $error("masked source reached the core");

   a_request_path: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(pend_q[eic_pkg::SRC_PIN_FIVE]) && mask_one_q[eic_pkg::M1_PIN_FIVE_IRQ_EN] && gie
      |-> irq_req ##1 src_q[eic_pkg::SRC_PIN_FIVE])
      else $error("pending enabled source not requested");

   a_gie_disable: assert property (@(posedge pclk) disable iff (!presetn)
      core_instr.disable_irqs_instr |=> !core_q[eic_pkg::CC_GLOBAL_IRQ_EN] && !irq_req)
      else $error("global enable survived disable instruction");

   a_gie_set: assert property (@(posedge pclk) disable iff (!presetn)
      (core_instr.enable_irqs_instr || core_instr.return_irq_instr)
      && !core_instr.disable_irqs_instr && !core_instr.irq_taken
      |=> core_q[eic_pkg::CC_GLOBAL_IRQ_EN])
      else $error("global enable not set by enable or return");

   a_gie_taken: assert property (@(posedge pclk) disable iff (!presetn)
      core_instr.irq_taken |=> !core_q[eic_pkg::CC_GLOBAL_IRQ_EN])
      else $error("global enable not cleared on taken interrupt");

   a_pin_zero_off: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(pend_q[eic_pkg::SRC_PIN_ZERO]) |-> $past(pin0_en) && $past(ext_irq_pin_zero, 2))
      else $error("pin zero flagged without function or falling edge");

   a_pin_three_code: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(pend_q[eic_pkg::SRC_PIN_THREE]) |-> $past(edge3) != 2'h3)
      else $error("pin three flagged under reserved edge code");

   a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg_q & ~eic_pkg::WMASK_EXT_IRQ_CONFIG) == 8'h00
      && (mask_one_q & ~eic_pkg::WMASK_IRQ_MASK_ONE) == 8'h00)
      else $error("reserved bit holds a one");

   a_core_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_cc && core_instr == 4'h0 ##1 !psel && core_instr == 4'h0
      ##1 psel && !penable && !pwrite && hit_cc
      ##1 access |-> prdata == {24'h0, $past(wbyte, 3)})
      else $error("core control did not read back its write");

   a_wdt_route: assert property (@(posedge pclk) disable iff (!presetn)
      wdt_expire |=> (wdt_rst_q == $past(wdt_to_reset))
      && (pend_q[eic_pkg::SRC_WATCHDOG] || $past(wdt_to_reset)))
      else $error("watchdog time-out routed wrongly");

   a_wdt_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !wdt_run |=> wdt_cnt_q == 16'h0000 && !wdt_rst_q)
      else $error("watchdog counted while disabled");
endmodule

// ---- dv/eic_core_model.sv ----
// Core-side partner: instruction pulses on command, takes requests promptly or slowly
`timescale 1ns/100ps
module eic_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic irq_req,
   input wire logic take_en,
   input wire logic [3:0] take_lat,
   input wire logic [1:0] cmd,
   output eic_pkg::eic_core_instr_s instr
);
   logic [3:0] wait_q;
   // One-cycle pulses; latency counted while a request stands, so slow cores are covered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= 4'h0;
         instr <= '0;
      end else begin
         instr.enable_irqs_instr <= (cmd == 2'h1);
         instr.disable_irqs_instr <= (cmd == 2'h2);
         instr.return_irq_instr <= (cmd == 2'h3);
         instr.irq_taken <= take_en && irq_req && !instr.irq_taken && wait_q == take_lat;
         wait_q <= (take_en && irq_req && wait_q != take_lat) ? wait_q + 4'h1 : 4'h0;
      end
   end
endmodule

// ---- dv/ext_irq_and_core_control_bench.sv ----
// Self-checking bench for the interrupt front end and core control block
`timescale 1ns/100ps
module ext_irq_and_core_control_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
   logic p0, p1, p3, p5, t2, wclr, irq_req, gpio, take_en, wrst, t2cnt, btick;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, seed;
   logic [9:0] irq_src;
   logic [3:0] take_lat;
   logic [1:0] cmd;
   logic [7:0] wv;
   logic [7:0] idx [4] = '{8'h0b, 8'h0e, 8'h0f, 8'h10};
   logic [7:0] wm [4] = '{8'hdb, 8'hef, 8'h7d, 8'hff};
   int pm [5] = '{0, 1, 2, 5, 6};
   int err_count, n_checks, ncyc, k, n;
   eic_pkg::eic_periph_s periph;
   eic_pkg::eic_core_instr_s instr;

   // Clock at 40 MHz
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // Short watchdog count keeps the run brief
   eic_top #(.WDT_TICKS(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_irq_pin_zero(p0), .ext_irq_pin_one(p1),
      .ext_irq_pin_three(p3), .ext_irq_pin_five(p5), .timer_two_pin(t2), .periph_evt(periph),
      .core_instr(instr), .watchdog_clear(wclr), .irq_req(irq_req), .irq_src(irq_src),
      .pin_zero_gpio(gpio), .timer_two_count(t2cnt), .base_timer_tick(btick),
      .watchdog_reset(wrst));

   eic_core_model core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
      .take_en(take_en), .take_lat(take_lat), .cmd(cmd), .instr(instr));

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected read-back: reserved bits stay zero
   function automatic logic [31:0] rb(input logic [7:0] v, input logic [7:0] m);
      return {24'h0, v & m};
   endfunction

   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask

   task cyc(input int c);
      repeat (c) @(posedge pclk);
   endtask

   // One APB transfer, then an idle cycle so no signal is driven twice in a step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      t = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 16);
      r = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task instr_cmd(input logic [1:0] c);
      cmd <= c;
      cyc(1);
      cmd <= 2'h0;
      cyc(3);
   endtask

   // Pulse pin one or three high for w cycles, then look at its pending flag
   task automatic glitch(input logic sel, input int w, input logic e);
      if (sel) p3 <= 1'b1;
      else p1 <= 1'b1;
      cyc(w);
      if (sel) p3 <= 1'b0;
      else p1 <= 1'b0;
      cyc(80);
      apb(1'b0, 12'h44, 32'h0);
      chk(sel ? r[3] : r[4], e);
      apb(1'b1, 12'h44, 32'h3ff);
   endtask

   // Hang guard
   always @(posedge pclk) begin
      ncyc <= ncyc + 1;
      if (ncyc == 20000) begin
         err_count++;
         $display("[ERR] %0t timeout", $time);
         tally_and_finish();
      end
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, p1, p3, t2, wclr} = '0;
      {take_en, take_lat, cmd} = '0;
      {p0, p5} = 2'h3;
      periph = '0;
      presetn = 1'b0;
      seed = 32'h82d8afe2;
      cyc(4);
      presetn <= 1'b1;
      cyc(1);
      // Reset values, random writes, reserved bits; watchdog enable kept off
      for (k = 0; k < 4; k++) begin
         apb(1'b0, {2'h0, idx[k], 2'h0}, 32'h0);
         chk(r, 32'h0);
         seed = nxt(seed);
         wv = seed[7:0] & 8'hf7;
         apb(1'b1, {2'h0, idx[k], 2'h0}, {24'h0, wv});
         apb(1'b0, {2'h0, idx[k], 2'h0}, 32'h0);
         chk(r, rb(wv, wm[k]));
         apb(1'b1, {2'h0, idx[k], 2'h0}, 32'h0);
      end
      apb(1'b0, 12'h48, 32'h0);
      chk(slv, 1'b1);
      chk(r, 32'h0);
      $display("test registers done");
      // Each peripheral source, masked out then in
      instr_cmd(2'h1);
      for (k = 0; k < 5; k++) begin
         periph <= 5'(1 << k);
         cyc(1);
         periph <= '0;
         cyc(2);
         chk(irq_req, 1'b0);
         apb(1'b1, 12'h38, 32'(1 << pm[k]));
         // Source vector trails the mask write by a cycle
         cyc(1);
         chk({irq_req, irq_src}, {1'b1, 10'(1 << pm[k])});
         apb(1'b1, 12'h44, 32'h3ff);
         chk(irq_req, 1'b0);
      end
      $display("test sources done");
      // Global enable by instructions and by a taken request
      periph <= 5'h10;
      cyc(1);
      periph <= '0;
      instr_cmd(2'h2);
      chk(irq_req, 1'b0);
      instr_cmd(2'h3);
      chk(irq_req, 1'b1);
      seed = nxt(seed);
      take_en <= 1'b1;
      take_lat <= seed[3:0];
      cyc(30);
      take_en <= 1'b0;
      apb(1'b0, 12'h40, 32'h0);
      chk({irq_req, r[6]}, 2'h0);
      apb(1'b1, 12'h44, 32'h3ff);
      $display("test global enable done");
      // Pin one: short and long pulses against both thresholds, both edges
      apb(1'b1, 12'h3c, 32'h04);
      apb(1'b1, 12'h2c, 32'h80);
      seed = nxt(seed);
      glitch(1'b0, 8 + int'(seed[2:0]) % 6, 1'b0);
      glitch(1'b0, 20, 1'b1);
      apb(1'b1, 12'h2c, 32'h82);
      glitch(1'b0, 20, 1'b1);
      apb(1'b1, 12'h2c, 32'h00);
      glitch(1'b0, 40 + int'(seed[4:0]) % 23, 1'b0);
      glitch(1'b0, 70, 1'b1);
      // Pin three: every edge code and a short pulse
      apb(1'b1, 12'h38, 32'h08);
      for (k = 0; k < 4; k++) begin
         apb(1'b1, 12'h2c, 32'(k << 3));
         glitch(1'b1, 12, k != 3);
      end
      apb(1'b1, 12'h2c, 32'h10);
      glitch(1'b1, 3 + int'(seed[1:0]) % 3, 1'b0);
      $display("test pins done");
      // Pin zero as plain I/O, then as interrupt input
      apb(1'b1, 12'h2c, 32'h00);
      p0 <= 1'b0;
      cyc(4);
      apb(1'b0, 12'h44, 32'h0);
      chk({gpio, r[8]}, 2'h0);
      p0 <= 1'b1;
      apb(1'b1, 12'h2c, 32'h40);
      p0 <= 1'b0;
      cyc(4);
      apb(1'b0, 12'h44, 32'h0);
      chk({gpio, r[8]}, 2'h3);
      p0 <= 1'b1;
      apb(1'b1, 12'h44, 32'h3ff);
      // Pin five falling edge, enabled and global enable on
      instr_cmd(2'h1);
      apb(1'b1, 12'h38, 32'h80);
      p5 <= 1'b0;
      cyc(3);
      chk({irq_req, irq_src[7]}, 2'h3);
      p5 <= 1'b1;
      apb(1'b1, 12'h44, 32'h3ff);
      instr_cmd(2'h2);
      // Timer two input edges, rising then falling select
      for (k = 0; k < 2; k++) begin
         apb(1'b1, 12'h2c, 32'(k));
         t2 <= 1'b1;
         cyc(2);
         chk(t2cnt, k == 0);
         t2 <= 1'b0;
         cyc(2);
         chk(t2cnt, k == 1);
      end
      // Timer prescale: 256 cycles hold a whole number of periods
      seed = nxt(seed);
      apb(1'b1, 12'h40, {29'h0, seed[2:0]});
      n = 0;
      repeat (256) begin
         cyc(1);
         n += btick;
      end
      chk(n, 256 >> (seed[2:0] + 1));
      $display("test timers done");
      // Watchdog: reset output, then interrupt output, then stopped
      apb(1'b1, 12'h40, 32'h88);
      for (n = 0; n < 40 && wrst !== 1'b1; n++) cyc(1);
      chk(n < 40, 1'b1);
      apb(1'b1, 12'h40, 32'h48);
      cyc(40);
      chk(irq_req, 1'b1);
      apb(1'b1, 12'h40, 32'h40);
      apb(1'b1, 12'h44, 32'h3ff);
      for (n = 0; n < 200 && irq_req !== 1'b1; n++) cyc(1);
      chk(n, 200);
      $display("test watchdog done");
      tally_and_finish();
   end
endmodule
